// ===== core_model.sv
// behavioural processor core: instruction timing, flags and program stack
`timescale 1ns/1ns
module core_model
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic push_strobe,
  input wire logic [17:0] push_data,
  output logic instr_last_cycle,
  output logic enable_interrupts_instruction,
  output logic return_from_interrupt_instruction,
  output logic [15:0] core_pc,
  output logic carry_flag,
  output logic zero_flag,
  output logic [15:0] stack_pc,
  output logic stack_carry,
  output logic stack_zero
);
  logic [1:0] phase_ff;
  logic [3:0] sp_ff;
  logic [17:0] stack_ff [16];
  // three-cycle instructions, last one flagged
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      phase_ff <= 2'h0;
    else
      phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
  assign instr_last_cycle = (phase_ff == 2'h2);
  // first fetch at zero; flags follow pc so a swapped pair shows
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      core_pc <= 16'h0000;
    else if (instr_last_cycle)
      core_pc <= core_pc + 16'h0003;
  assign carry_flag = core_pc[0];
  assign zero_flag = core_pc[1];
  // stack of sixteen, enough for the bench's nesting
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      sp_ff <= 4'h0;
    else if (push_strobe)
    begin
      stack_ff[sp_ff] <= push_data;
      sp_ff <= sp_ff + 4'h1;
    end
    else if (return_from_interrupt_instruction)
      sp_ff <= sp_ff - 4'h1;
  assign {stack_carry, stack_zero, stack_pc} = stack_ff[sp_ff - 4'h1];
  initial
  begin
    enable_interrupts_instruction = 1'b0;
    return_from_interrupt_instruction = 1'b0;
  end
  // one-cycle instruction pulses
  task automatic open_irqs;
    @(posedge clk);
    enable_interrupts_instruction <= 1'b1;
    @(posedge clk);
    enable_interrupts_instruction <= 1'b0;
  endtask : open_irqs
  task automatic leave_routine;
    @(posedge clk);
    return_from_interrupt_instruction <= 1'b1;
    @(posedge clk);
    return_from_interrupt_instruction <= 1'b0;
  endtask : leave_routine
endmodule : core_model

// ===== irq_ctrl_checker_props.sv
// concurrent checks on the interrupt controller's core-side ports
`timescale 1ns/1ns
module irq_ctrl_checker
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_last_cycle,
  input wire logic enable_interrupts_instruction,
  input wire logic [15:0] core_pc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [15:0] stack_pc,
  input wire logic stack_carry,
  input wire logic stack_zero,
  input wire logic call_active,
  input wire logic push_strobe,
  input wire logic [17:0] push_data,
  input wire logic restore_strobe,
  input wire logic [17:0] restore_data,
  input wire logic [15:0] vector_addr,
  input wire logic jump_strobe,
  input wire logic gie,
  input wire logic irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // takes only from an instruction end with interrupts open
  a_take_at_end:
    assert property (push_strobe |-> $past(instr_last_cycle) && $past(gie))
    else $error("take away from instruction end");
  a_ack_closes:
    assert property (push_strobe |-> !gie)
    else $error("global enable kept on take");
  a_pending_drop:
    assert property (push_strobe |-> !irq_pending)
    else $error("pending bit kept on take");
  a_push_state:
    assert property (push_strobe |->
      push_data == {$past(carry_flag), $past(zero_flag), $past(core_pc)})
    else $error("pushed state wrong");
  a_return_state:
    assert property (restore_strobe |->
      gie && restore_data == {$past(stack_carry), $past(stack_zero), $past(stack_pc)})
    else $error("return state wrong");
  // a take in the same edge would close it again, hence the guard on gie
  a_enable_reopens:
    assert property (enable_interrupts_instruction && !call_active && !gie |=> gie)
    else $error("enable did not reopen");
  a_vector_map:
    assert property (push_strobe |-> vector_addr inside {16'h0002, 16'h0004, 16'h0006,
      16'h0008, 16'h000A, 16'h000C, 16'h0014, 16'h0016})
    else $error("vector outside table");
  a_call_length:
    assert property ($rose(call_active) |-> ##14 call_active ##1 !call_active)
    else $error("call phase length wrong");
  a_jump_timing:
    assert property (push_strobe |-> ##10 jump_strobe && call_active)
    else $error("jump not ten cycles after call");
endmodule : irq_ctrl_checker

bind usb_mcu_interrupt_controller irq_ctrl_checker irq_ctrl_checker_inst (.*);

// ===== irq_ctrl_pkg.sv
// types shared by the interrupt controller
package irq_ctrl_pkg;
  // source index is priority order, lowest vector first
  typedef enum logic [3:0]
  {
    SRC_BUS_RESET = 4'h0,
    SRC_TICK_SHORT = 4'h1,
    SRC_TICK_LONG = 4'h2,
    SRC_ENDPOINT_ZERO = 4'h3,
    SRC_ENDPOINT_ONE = 4'h4,
    SRC_ENDPOINT_TWO = 4'h5,
    SRC_DAC = 4'h6,
    SRC_GPIO = 4'h7
  } irq_src_e;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_JMP = 2'b11
  } ack_state_e;

  typedef logic [7:0] src_vec_t;
endpackage : irq_ctrl_pkg

// ===== irq_ctrl_regs.svh
// register offsets, field positions, vectors and timing counts for the interrupt controller
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// register index 0x21 is not a multiple of four, so byte address is index times four
`define EP_IRQ_EN_IDX 8'h21
`define EP_IRQ_EN_ADDR 12'h084
`define GLB_IRQ_EN_IDX 8'h20
`define GLB_IRQ_EN_ADDR 12'h080
`define CPU_STATUS_IDX 8'hFF
`define CPU_STATUS_ADDR 12'h3FC
`define IRQ_SRC_STATUS_IDX 8'h22
`define IRQ_SRC_STATUS_ADDR 12'h088

// writable field masks and reset values
`define GLB_IRQ_EN_MASK 8'h37
`define EP_IRQ_EN_MASK 8'h07
`define IRQ_EN_RESET 8'h00
`define CPU_STATUS_PENDING_BIT 7
`define CPU_STATUS_GIE_BIT 2

// global enable bit positions
`define GLB_BUS_RESET_BIT 0
`define GLB_TICK_SHORT_BIT 1
`define GLB_TICK_LONG_BIT 2
`define GLB_DAC_BIT 4
`define GLB_GPIO_BIT 5

// vector table
`define VEC_RESET 16'h0000
`define VEC_BUS_RESET 16'h0002
`define VEC_TICK_SHORT 16'h0004
`define VEC_TICK_LONG 16'h0006
`define VEC_ENDPOINT_ZERO 16'h0008
`define VEC_ENDPOINT_ONE 16'h000A
`define VEC_ENDPOINT_TWO 16'h000C
`define VEC_DAC 16'h0014
`define VEC_GPIO 16'h0016
`define VEC_SPACING 16'h0002

// timing: clock 100 MHz, times in ns
`define CLK_PERIOD_NS 10
`define SE0_MIN_NS 8000
`define SE0_CYCLES ((`SE0_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CALL_CYCLES 10
`define JMP_CYCLES 5

`endif

// ===== usb_mcu_interrupt_controller.sv
// interrupt controller: enables, latches, priority pick and acknowledge sequencer
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"

module usb_mcu_interrupt_controller
(
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // usb line pins, asynchronous
  input wire logic dplus,
  input wire logic dminus,
  // request strobes from same-clock sources
  input wire logic tick_short,
  input wire logic tick_long,
  input wire logic endpoint_zero,
  input wire logic endpoint_one,
  input wire logic endpoint_two,
  input wire logic dac_request,
  input wire logic gpio_request,
  // processor core handshake
  input wire logic instr_last_cycle,
  input wire logic enable_interrupts_instruction,
  input wire logic disable_interrupts_instruction,
  input wire logic return_from_interrupt_instruction,
  input wire logic [15:0] core_pc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [15:0] stack_pc,
  input wire logic stack_carry,
  input wire logic stack_zero,
  output logic call_active,
  output logic push_strobe,
  output logic [17:0] push_data,
  output logic restore_strobe,
  output logic [17:0] restore_data,
  output logic [15:0] vector_addr,
  output logic jump_strobe,
  output logic gie,
  output logic irq_pending
);

  logic [7:0] glb_en_ff;
  logic [7:0] ep_en_ff;
  irq_ctrl_pkg::src_vec_t latch_ff;
  irq_ctrl_pkg::src_vec_t req_set;
  irq_ctrl_pkg::src_vec_t en_map;
  irq_ctrl_pkg::src_vec_t active;
  irq_ctrl_pkg::src_vec_t clr_ff;
  irq_ctrl_pkg::ack_state_e state_ff;
  logic [3:0] cnt_ff;
  logic [2:0] sel_idx;
  logic any_active;
  logic [1:0] dp_sync_ff;
  logic [1:0] dm_sync_ff;
  logic [9:0] se0_cnt_ff;
  logic bus_reset_ff;
  logic bus_reset_req;
  logic [15:0] vec_table [0:7];
  logic ap_valid_ff;
  logic ap_write_ff;
  logic [11:0] ap_addr_ff;
  logic [7:0] status_rd;

  // two-flop synchronisers for the usb line pins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_sync_ff <= 2'h0;
      dm_sync_ff <= 2'h0;
    end
    else
    begin
      dp_sync_ff <= {dp_sync_ff[0], dplus};
      dm_sync_ff <= {dm_sync_ff[0], dminus};
    end
  end

  // se0 duration counter, one request per se0 episode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      se0_cnt_ff <= 10'h000;
      bus_reset_ff <= 1'b0;
    end
    else if (!dp_sync_ff[1] && !dm_sync_ff[1])
    begin
      if (se0_cnt_ff != 10'(`SE0_CYCLES))
        se0_cnt_ff <= se0_cnt_ff + 10'h001;
      bus_reset_ff <= (se0_cnt_ff == 10'(`SE0_CYCLES));
    end
    else
    begin
      se0_cnt_ff <= 10'h000;
      bus_reset_ff <= 1'b0;
    end
  end

  // rising edge of the held condition gives a single request
  assign bus_reset_req = (!dp_sync_ff[1] && !dm_sync_ff[1])
    && (se0_cnt_ff == 10'(`SE0_CYCLES)) && !bus_reset_ff;

  // raw request vector in priority order
  assign req_set = {gpio_request, dac_request, endpoint_two, endpoint_one,
    endpoint_zero, tick_long, tick_short, bus_reset_req};

  // enable map: each source has its own bit
  assign en_map = {glb_en_ff[`GLB_GPIO_BIT], glb_en_ff[`GLB_DAC_BIT], ep_en_ff[2:0],
    glb_en_ff[`GLB_TICK_LONG_BIT], glb_en_ff[`GLB_TICK_SHORT_BIT],
    glb_en_ff[`GLB_BUS_RESET_BIT]};

  assign active = latch_ff & en_map;
  assign any_active = |active;

  // vector table, two bytes apart, unused entries skipped
  assign vec_table[0] = `VEC_BUS_RESET;
  assign vec_table[1] = `VEC_TICK_SHORT;
  assign vec_table[2] = `VEC_TICK_LONG;
  assign vec_table[3] = `VEC_ENDPOINT_ZERO;
  assign vec_table[4] = `VEC_ENDPOINT_ONE;
  assign vec_table[5] = `VEC_ENDPOINT_TWO;
  assign vec_table[6] = `VEC_DAC;
  assign vec_table[7] = `VEC_GPIO;

  // lowest index wins; the others stay pending
  always_comb
  begin
    sel_idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (active[i])
        sel_idx = 3'(i);
  end

  // per-source latches; a new request beats a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_latch
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          latch_ff[g] <= 1'b0;
        else if (req_set[g])
          latch_ff[g] <= 1'b1;
        else if (clr_ff[g])
          latch_ff[g] <= 1'b0;
      end
    end
  endgenerate

  // acknowledge sequencer: decide at last instruction cycle, call, then jump
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= irq_ctrl_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      clr_ff <= 8'h00;
      gie <= 1'b0;
      call_active <= 1'b0;
      push_strobe <= 1'b0;
      push_data <= 18'h00000;
      vector_addr <= `VEC_RESET;
      jump_strobe <= 1'b0;
      restore_strobe <= 1'b0;
      restore_data <= 18'h00000;
    end
    else
    begin
      clr_ff <= 8'h00;
      push_strobe <= 1'b0;
      jump_strobe <= 1'b0;
      restore_strobe <= 1'b0;
      case (state_ff)
        irq_ctrl_pkg::ST_IDLE:
        begin
          if (instr_last_cycle && gie && any_active)
          begin
            gie <= 1'b0;
            clr_ff <= 8'(8'h01 << sel_idx);
            vector_addr <= vec_table[sel_idx];
            push_strobe <= 1'b1;
            push_data <= {carry_flag, zero_flag, core_pc};
            call_active <= 1'b1;
            cnt_ff <= 4'(`CALL_CYCLES - 1);
            state_ff <= irq_ctrl_pkg::ST_CALL;
          end
          else if (return_from_interrupt_instruction)
          begin
            restore_strobe <= 1'b1;
            restore_data <= {stack_carry, stack_zero, stack_pc};
            gie <= 1'b1;
          end
          else if (enable_interrupts_instruction)
            gie <= 1'b1;
          else if (disable_interrupts_instruction)
            gie <= 1'b0;
        end
        irq_ctrl_pkg::ST_CALL:
        begin
          if (cnt_ff == 4'h0)
          begin
            jump_strobe <= 1'b1;
            cnt_ff <= 4'(`JMP_CYCLES - 1);
            state_ff <= irq_ctrl_pkg::ST_JMP;
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        irq_ctrl_pkg::ST_JMP:
        begin
          if (cnt_ff == 4'h0)
          begin
            call_active <= 1'b0;
            state_ff <= irq_ctrl_pkg::ST_IDLE;
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        default:
          state_ff <= irq_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // pending flag: cleared by acknowledge, re-raised by next recognised source
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_pending <= 1'b0;
    else if (state_ff == irq_ctrl_pkg::ST_IDLE && instr_last_cycle && gie && any_active)
      irq_pending <= 1'b0;
    else if (state_ff == irq_ctrl_pkg::ST_IDLE)
      irq_pending <= any_active;
  end

  // ahb address phase capture; slave is always ready, response OKAY
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 12'h000;
    end
    else if (hready)
    begin
      ap_valid_ff <= hsel && htrans[1];
      ap_write_ff <= hwrite;
      ap_addr_ff <= haddr;
    end
  end

  // enable registers; reserved bits stay zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      glb_en_ff <= `IRQ_EN_RESET;
      ep_en_ff <= `IRQ_EN_RESET;
    end
    else if (ap_valid_ff && ap_write_ff)
    begin
      if (ap_addr_ff == `GLB_IRQ_EN_ADDR)
        glb_en_ff <= hwdata[7:0] & `GLB_IRQ_EN_MASK;
      if (ap_addr_ff == `EP_IRQ_EN_ADDR)
        ep_en_ff <= hwdata[7:0] & `EP_IRQ_EN_MASK;
    end
  end

  // status view: pending bit and global enable bit
  assign status_rd = 8'((irq_pending ? 8'h80 : 8'h00) | (gie ? 8'h04 : 8'h00));

  // read data registered in the address phase so it is ready in the data phase
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr)
        `GLB_IRQ_EN_ADDR: hrdata <= {24'h000000, glb_en_ff};
        `EP_IRQ_EN_ADDR: hrdata <= {24'h000000, ep_en_ff};
        `CPU_STATUS_ADDR: hrdata <= {24'h000000, status_rd};
        `IRQ_SRC_STATUS_ADDR: hrdata <= {24'h000000, latch_ff};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // zero wait states: ready and okay from reset onward
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : usb_mcu_interrupt_controller

// ===== usb_mcu_interrupt_controller_tb_top.sv
// bench: register access, masking, vectors, priority and bus reset
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module usb_mcu_interrupt_controller_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic dplus = 1'b0;
  logic dminus = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [6:0] req = 7'h00;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, call_active, push_strobe, restore_strobe, jump_strobe, gie;
  logic irq_pending, instr_last_cycle, carry_flag, zero_flag, stack_carry, stack_zero;
  logic enable_interrupts_instruction, return_from_interrupt_instruction;
  logic [15:0] core_pc, stack_pc, vector_addr;
  logic [17:0] push_data, restore_data;
  logic [15:0] vt [7] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h0014, 16'h0016};
  int mismatches = 0;
  int n_checks = 0;
  int pushes = 0;
  always #5 clk = ~clk;
  // count takes so a masked source can be seen to stay quiet
  always @(posedge clk)
    if (push_strobe === 1'b1)
      pushes++;
  usb_mcu_interrupt_controller usb_mcu_interrupt_controller_inst
  (
    .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .dplus, .dminus, .tick_short(req[0]), .tick_long(req[1]),
    .endpoint_zero(req[2]), .endpoint_one(req[3]), .endpoint_two(req[4]),
    .dac_request(req[5]), .gpio_request(req[6]), .instr_last_cycle,
    .enable_interrupts_instruction, .disable_interrupts_instruction(1'b0),
    .return_from_interrupt_instruction, .core_pc, .carry_flag, .zero_flag, .stack_pc,
    .stack_carry, .stack_zero, .call_active, .push_strobe, .push_data, .restore_strobe,
    .restore_data, .vector_addr, .jump_strobe, .gie, .irq_pending
  );
  core_model core_model_inst
  (
    .clk, .resetn, .push_strobe, .push_data, .instr_last_cycle,
    .enable_interrupts_instruction, .return_from_interrupt_instruction, .core_pc,
    .carry_flag, .zero_flag, .stack_pc, .stack_carry, .stack_zero
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop;
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  function automatic logic hit(input int what);
    case (what)
      0: return hreadyout === 1'b1;
      1: return push_strobe === 1'b1;
      default: return call_active === 1'b0;
    endcase
  endfunction : hit
  // bounded wait on bus ready, a take, or the end of a call
  task automatic await(input int what);
    int n;
    n = 0;
    @(posedge clk);
    while (!hit(what) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      mismatches++;
      $display("ERROR %0t wait limit reached", $time);
      report_and_stop();
    end
  endtask : await
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    await(0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    await(0);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus
  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    req <= m;
    @(posedge clk);
    req <= 7'h00;
  endtask : pulse
  // take one interrupt, check its vector, return from it
  task automatic take(input logic [15:0] v);
    await(1);
    check(vector_addr, v);
    check(gie, 1'b0);
    await(2);
    core_model_inst.leave_routine();
  endtask : take
  initial
  begin
    logic [31:0] d;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    check(vector_addr, 16'h0000);
    bus(1'b0, `GLB_IRQ_EN_ADDR, 32'h0, d);
    check(d, 32'h0);
    bus(1'b0, `EP_IRQ_EN_ADDR, 32'h0, d);
    check(d, 32'h0);
    bus(1'b1, `GLB_IRQ_EN_ADDR, 32'hFF, d);
    bus(1'b1, `EP_IRQ_EN_ADDR, 32'hFE, d);
    bus(1'b0, `GLB_IRQ_EN_ADDR, 32'h0, d);
    check(d, 32'h37);
    bus(1'b0, `EP_IRQ_EN_ADDR, 32'h0, d);
    check(d, 32'h06);
    bus(1'b0, 12'h0C0, 32'h0, d);
    check(d, 32'h0);
    // endpoint zero masked: its latch must wait for the enable
    pulse(7'h04);
    core_model_inst.open_irqs();
    repeat (30) @(posedge clk);
    check(pushes, 32'h0);
    // masked latch is not active: pending clear, global enable open
    bus(1'b0, `CPU_STATUS_ADDR, 32'h0, d);
    check(d, 32'h04);
    bus(1'b1, `EP_IRQ_EN_ADDR, 32'h07, d);
    take(16'h0008);
    for (int i = 0; i < 7; i++)
    begin
      pulse(7'(1 << i));
      take(vt[i]);
    end
    pulse(7'h11);
    await(1);
    check(vector_addr, 16'h0004);
    await(2);
    // endpoint two still waits behind the closed global enable
    bus(1'b0, `CPU_STATUS_ADDR, 32'h0, d);
    check(d, 32'h80);
    core_model_inst.leave_routine();
    take(16'h000C);
    // an se0 a little under the limit must not raise bus reset
    dminus <= 1'b0;
    repeat (`SE0_CYCLES - 10) @(posedge clk);
    dminus <= 1'b1;
    repeat (30) @(posedge clk);
    check(pushes, 32'h0000000A);
    // the take lands inside a long se0, so watch for it while se0 holds
    dminus <= 1'b0;
    repeat (`SE0_CYCLES) @(posedge clk);
    take(16'h0002);
    dminus <= 1'b1;
    // firmware closes both ticks before suspend; tick requests then stay quiet
    bus(1'b1, `GLB_IRQ_EN_ADDR, 32'h31, d);
    pulse(7'h03);
    repeat (30) @(posedge clk);
    check(pushes, 32'h0000000B);
    report_and_stop();
  end
endmodule : usb_mcu_interrupt_controller_tb_top
